// ---- logic/cstp_pkg.sv ----
// Constants shared by the configuration, status and test port
package cstp_pkg;
    localparam int CLK_SYS_PERIOD_NS  = 4;
    localparam int RECONF_MIN_NS      = 320;
    localparam int RECONF_MIN_CYC     = (RECONF_MIN_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    localparam int CNT_W              = 16;
    localparam int IR_LEN             = 4;
    localparam int BYPASS_LEN         = 1;
    localparam int USER_W             = 8;
    localparam int CFG_TIME_CYC       = 64;
    localparam logic [IR_LEN-1:0] IR_RESET_VAL   = 4'h1;
    localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [IR_LEN-1:0] INS_BYPASS     = 4'hf;
    localparam logic [IR_LEN-1:0] INS_USERREG    = 4'h8;
    localparam int USERREG_LEN        = 8;
    localparam logic [USERREG_LEN-1:0] USERREG_RESET = 8'h00;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAP_DR     = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPD_DR     = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAP_IR     = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPD_IR     = 16'h8000
    } cstp_tap_t;

    typedef enum logic [3:0] {
        CFG_IDLE = 4'h1,
        CFG_LOAD = 4'h2,
        CFG_WAIT = 4'h4,
        CFG_USER = 4'h8
    } cstp_cfg_t;
endpackage

// ---- logic/cstp_sync.sv ----
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module cstp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

// ---- logic/cstp_top.sv ----
// Configuration request, done status and test access port logic
//
// How it works
// - Request low at least minimum width, then rising edge starts a new configuration.
// - Request only restarts configuration; user logic reset stays untouched.
// - Done pin only pulled low, open drain; released once configuration completes.
// - User mode held off while the done pin reads low from outside.
// - Mode select and data input sampled on each test clock rising edge.
// - Serial output changes only after a test clock falling edge.
// - Undriven mode select or data input reads as one.
// - Serial input goes to instruction or selected data register by state.
// - Shift path length equals the selected register length.
// - Serial output disabled whenever no shift is in progress.
// - Dedicated pins keep their function; never offered as user I/O.
// - Unselected multi-function pin serves as an ordinary user I/O.
`timescale 1ns/1ps
module cstp_top
    import cstp_pkg::*;
#(
    parameter int CFG_CYC = CFG_TIME_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic               reconf_req_b,
    input  wire logic               config_done_flag_i,
    output logic                    config_done_flag_o,
    output logic                    config_done_flag_oe,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tms_oe_ext,
    input  wire logic               tdi,
    input  wire logic               tdi_oe_ext,
    output logic                    tdo,
    output logic                    tdo_oe,
    input  wire logic               alt_func_sel,
    input  wire logic               alt_func_out,
    output logic                    alt_func_in,
    input  wire logic               user_io_pin_i,
    output logic                    user_io_pin_o,
    output logic                    user_io_pin_oe,
    input  wire logic               user_out,
    input  wire logic               user_oe,
    output logic                    user_in,
    output logic                    user_mode,
    output logic                    cfg_busy,
    output logic [USERREG_LEN-1:0]  user_reg
);
    import cstp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; pull-ups modelled by the undriven flags
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    logic       req_s, done_s, tck_s, tms_s, tdi_s, uio_s;

    assign pin_raw = {user_io_pin_i,
                      tdi_oe_ext ? tdi : 1'b1,
                      tms_oe_ext ? tms : 1'b1,
                      tck, config_done_flag_i, reconf_req_b};

    // Test clock resets low like its idle pin, so no false edge follows reset
    cstp_sync #(.W(6), .INIT(6'h3b)) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       (pin_raw),
        .q       (pin_s)
    );
    assign {uio_s, tdi_s, tms_s, tck_s, done_s, req_s} = pin_s;

    ////////////////////////////////////////////////////////////////////////
    // Configuration sequencer
    cstp_cfg_t          cfg_st, next_cfg_st;
    logic [CNT_W-1:0]   low_cnt, next_low_cnt;
    logic [CNT_W-1:0]   cfg_cnt, next_cfg_cnt;
    logic               req_d, next_req_d;
    logic               req_armed, next_req_armed;
    logic               restart;

    // Restart needs a qualified low pulse followed by its rising edge
    assign restart = req_s && !req_d && req_armed;

    always_comb begin
        next_req_d     = req_s;
        next_low_cnt   = low_cnt;
        next_req_armed = req_armed;
        next_cfg_st    = cfg_st;
        next_cfg_cnt   = cfg_cnt;
        if (!req_s) begin
            if (low_cnt != CNT_W'(RECONF_MIN_CYC))
                next_low_cnt = low_cnt + 1'b1;
            if (low_cnt >= CNT_W'(RECONF_MIN_CYC - 1))
                next_req_armed = 1'b1;
        end else begin
            next_low_cnt   = '0;
            next_req_armed = 1'b0;
        end
        case (cfg_st)
            CFG_IDLE: begin
                next_cfg_st  = CFG_LOAD;
                next_cfg_cnt = '0;
            end
            CFG_LOAD: begin
                if (cfg_cnt == CNT_W'(CFG_CYC - 1))
                    next_cfg_st = CFG_WAIT;
                else
                    next_cfg_cnt = cfg_cnt + 1'b1;
            end
            CFG_WAIT: begin
                if (done_s)
                    next_cfg_st = CFG_USER;
            end
            CFG_USER: begin
                if (!done_s)
                    next_cfg_st = CFG_WAIT;
            end
            default: next_cfg_st = CFG_IDLE;
        endcase
        if (restart) begin
            next_cfg_st  = CFG_LOAD;
            next_cfg_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_st    <= CFG_IDLE;
            cfg_cnt   <= '0;
            low_cnt   <= '0;
            req_d     <= 1'b1;
            req_armed <= 1'b0;
        end else begin
            cfg_st    <= next_cfg_st;
            cfg_cnt   <= next_cfg_cnt;
            low_cnt   <= next_low_cnt;
            req_d     <= next_req_d;
            req_armed <= next_req_armed;
        end
    end

    // Open drain: data always low, only the enable moves
    assign config_done_flag_o  = 1'b0;
    assign config_done_flag_oe = (cfg_st == CFG_IDLE) || (cfg_st == CFG_LOAD);
    assign cfg_busy            = config_done_flag_oe;
    // Plain status; the 12 us settle is the system's duty
    assign user_mode           = (cfg_st == CFG_USER);

    ////////////////////////////////////////////////////////////////////////
    // Multi-function pin muxing; dedicated pins have no user path
    assign user_io_pin_o  = alt_func_sel ? alt_func_out : user_out;
    assign user_io_pin_oe = alt_func_sel ? 1'b1 : user_oe;
    assign user_in        = alt_func_sel ? 1'b0 : uio_s;
    assign alt_func_in    = alt_func_sel ? uio_s : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Test access port, stepped on edges of the sampled test clock
    cstp_tap_t                tap_st, next_tap_st;
    logic                     tck_d, next_tck_d;
    logic                     tck_rise, tck_fall;
    logic [IR_LEN-1:0]        ir_sh, next_ir_sh, ir, next_ir;
    logic [USERREG_LEN-1:0]   ur_sh, next_ur_sh, ur, next_ur;
    logic                     byp, next_byp;
    logic                     next_tdo, next_tdo_oe;

    assign tck_rise = tck_s && !tck_d;
    assign tck_fall = !tck_s && tck_d;

    function automatic cstp_tap_t tap_step(input cstp_tap_t s, input logic m);
        case (s)
            TAP_RESET:    tap_step = m ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     tap_step = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   tap_step = m ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_step = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_step = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   tap_step = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   tap_step = m ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_step = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_step = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   tap_step = m ? TAP_SEL_DR   : TAP_IDLE;
            default:      tap_step = TAP_RESET;
        endcase
    endfunction

    always_comb begin
        next_tck_d  = tck_s;
        next_tap_st = tap_st;
        next_ir_sh  = ir_sh;
        next_ir     = ir;
        next_ur_sh  = ur_sh;
        next_ur     = ur;
        next_byp    = byp;
        next_tdo    = tdo;
        next_tdo_oe = tdo_oe;
        if (tck_rise) begin
            next_tap_st = tap_step(tap_st, tms_s);
            case (tap_st)
                TAP_RESET:    next_ir    = IR_RESET_VAL;
                TAP_CAP_IR:   next_ir_sh = IR_CAPTURE_VAL;
                TAP_SHIFT_IR: next_ir_sh = {tdi_s, ir_sh[IR_LEN-1:1]};
                TAP_UPD_IR:   next_ir    = ir_sh;
                TAP_CAP_DR: begin
                    next_byp   = 1'b0;
                    next_ur_sh = ur;
                end
                TAP_SHIFT_DR: begin
                    if (ir == INS_USERREG)
                        next_ur_sh = {tdi_s, ur_sh[USERREG_LEN-1:1]};
                    else
                        next_byp = tdi_s;
                end
                TAP_UPD_DR: begin
                    if (ir == INS_USERREG)
                        next_ur = ur_sh;
                end
                default: ;
            endcase
        end
        // Output moves only on the falling edge, half a cycle before sampling
        if (tck_fall) begin
            next_tdo_oe = (tap_st == TAP_SHIFT_IR) || (tap_st == TAP_SHIFT_DR);
            if (tap_st == TAP_SHIFT_IR)
                next_tdo = ir_sh[0];
            else if (ir == INS_USERREG)
                next_tdo = ur_sh[0];
            else
                next_tdo = byp;
        end
    end

    // Test logic resets from the system reset rst_b, and the TAP_RESET state reloads ir; the request pin never clears it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tck_d  <= 1'b0;
            tap_st <= TAP_RESET;
            ir_sh  <= '0;
            ir     <= IR_RESET_VAL;
            ur_sh  <= '0;
            ur     <= USERREG_RESET;
            byp    <= 1'b0;
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tck_d  <= next_tck_d;
            tap_st <= next_tap_st;
            ir_sh  <= next_ir_sh;
            ir     <= next_ir;
            ur_sh  <= next_ur_sh;
            ur     <= next_ur;
            byp    <= next_byp;
            tdo    <= next_tdo;
            tdo_oe <= next_tdo_oe;
        end
    end

    assign user_reg = ur;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_done_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_b)
        config_done_flag_o == 1'b0) else $error("done pin driven high");
    chk_user_needs_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
        user_mode |-> $past(done_s)) else $error("user mode with done low");
    chk_done_low_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (user_mode && !done_s) |=> !user_mode) else $error("user mode kept");
    chk_restart_drives: assert property (@(posedge clk_sys) disable iff (!rst_b)
        restart |=> config_done_flag_oe && !user_mode) else $error("restart ignored");
    chk_short_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (req_s && !req_d && low_cnt < CNT_W'(RECONF_MIN_CYC - 1)) |-> !restart)
        else $error("short pulse restarted");
    chk_tdo_fall_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(tck_fall) |-> $stable(tdo)) else $error("tdo moved off falling edge");
    chk_tdo_oe_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($past(tck_fall) && $past(tap_st) == TAP_IDLE) |-> !tdo_oe) else $error("tdo driven idle");
    chk_tap_reset_tms: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tck_rise && tms_s && tap_st == TAP_SEL_IR) |=> tap_st == TAP_RESET)
        else $error("tap reset path wrong");
    chk_tap_sample: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !tck_rise |=> $stable(tap_st)) else $error("tap moved without rising edge");
    chk_ir_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tck_rise && tap_st == TAP_SHIFT_IR) |=> ir_sh[IR_LEN-1] == $past(tdi_s))
        else $error("ir shift wrong");
    chk_dr_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tck_rise && tap_st == TAP_SHIFT_DR && ir == INS_USERREG) |=> ur_sh[USERREG_LEN-1] == $past(tdi_s))
        else $error("user register shift wrong");
    chk_bypass_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tck_rise && tap_st == TAP_CAP_DR) |=> !byp) else $error("bypass capture wrong");
    chk_ir_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tck_rise && tap_st == TAP_UPD_IR) |=> ir == $past(ir_sh))
        else $error("instruction update wrong");
    chk_tdo_oe_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($past(tck_fall) && ($past(tap_st) == TAP_SHIFT_IR || $past(tap_st) == TAP_SHIFT_DR)) |-> tdo_oe)
        else $error("tdo not driven in shift");
    chk_tdo_oe_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(tck_fall) |-> $stable(tdo_oe)) else $error("tdo enable moved off falling edge");
    chk_restart_keeps_user: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (restart && !tck_rise) |=> $stable(ur)) else $error("restart touched user register");
endmodule

// ---- bench/cstp_host_model.sv ----
// Host side model: test clock and pins, request pin, pulled-up done wire
`timescale 1ns/1ps
module cstp_host_model (
    input  wire logic       clk_sys,
    input  wire logic       config_done_flag_oe,
    input  wire logic       tdo,
    input  wire logic       tdo_oe,
    output logic            config_done_flag_i,
    output logic            reconf_req_b,
    output logic            tck,
    output logic            tms,
    output logic            tdi,
    output logic            tms_oe_ext,
    output logic            tdi_oe_ext
);
    logic done_hold;

    ////////////////////////////////////////////////////////////////////////
    // Wire reads high only while nobody pulls it low
    assign config_done_flag_i = ~(config_done_flag_oe | done_hold);

    initial begin
        done_hold = 1'b0;
        reconf_req_b = 1'b1;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        tms_oe_ext = 1'b1;
        tdi_oe_ext = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One test clock of 48 ns; clock stands low between steps
    // Released pins toggle so a missed pull-up cannot pass by luck
    task automatic step(input logic m, input logic d, output logic [1:0] o);
        tms <= tms_oe_ext ? m : ~tms;
        tdi <= tdi_oe_ext ? d : ~tdi;
        repeat (5) @(posedge clk_sys);
        o = {tdo_oe, tdo};
        tck <= 1'b1;
        repeat (6) @(posedge clk_sys);
        tck <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Request held low n cycles, released on return
    task automatic pulse(input int n);
        reconf_req_b <= 1'b0;
        repeat (n) @(posedge clk_sys);
        reconf_req_b <= 1'b1;
    endtask
endmodule

// ---- bench/tb_config_status_test_port.sv ----
// Self-checking bench for the configuration, status and test port
`timescale 1ns/1ps
module tb_config_status_test_port;
    import cstp_pkg::*;
    localparam int CFG_CYC = 8;
    // System settle time after the done wire rises, before user mode is relied on
    localparam int USER_SETTLE_CYC = 12000 / CLK_SYS_PERIOD_NS;
    logic clk_sys, rst_b, reconf_req_b, config_done_flag_i, config_done_flag_o, config_done_flag_oe;
    logic tck, tms, tms_oe_ext, tdi, tdi_oe_ext, tdo, tdo_oe, alt_func_sel, alt_func_out, alt_func_in;
    logic user_io_pin_i, user_io_pin_o, user_io_pin_oe, user_out, user_oe, user_in, user_mode, cfg_busy;
    logic [USERREG_LEN-1:0] user_reg, va, vb;
    int   error_cnt = 0, total_checks = 0;
    logic [IR_LEN-1:0] byp_codes [3] = '{INS_BYPASS, 4'h0, 4'h3};

    cstp_top #(.CFG_CYC(CFG_CYC)) cstp_top_inst (
        .clk_sys, .rst_b, .reconf_req_b, .config_done_flag_i, .config_done_flag_o, .config_done_flag_oe,
        .tck, .tms, .tms_oe_ext, .tdi, .tdi_oe_ext, .tdo, .tdo_oe, .alt_func_sel, .alt_func_out, .alt_func_in,
        .user_io_pin_i, .user_io_pin_o, .user_io_pin_oe, .user_out, .user_oe, .user_in, .user_mode, .cfg_busy,
        .user_reg
    );
    cstp_host_model cstp_host_model_inst (
        .clk_sys, .config_done_flag_oe, .tdo, .tdo_oe, .config_done_flag_i, .reconf_req_b,
        .tck, .tms, .tdi, .tms_oe_ext, .tdi_oe_ext
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_for(ref logic s, input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk(s, v, what);
        if (s !== v)
            end_sim;
    endtask

    // Walk the controller; no step outside a shift state may enable the output
    task automatic go(input logic [7:0] seq, input int n);
        logic [1:0] o;
        for (int i = 0; i < n; i++) begin
            cstp_host_model_inst.step(seq[i], 1'b0, o);
            chk(o[1], 1'b0, "output enabled outside shift");
        end
    endtask

    // Queue model: captured bits leave first, each input bit len steps later
    task automatic shift(input int len, input logic [7:0] cap, input logic [7:0] din, input int n);
        logic [1:0] o;
        logic       q[$];
        for (int i = 0; i < len; i++)
            q.push_back(cap[i]);
        for (int i = 0; i < n; i++) begin
            q.push_back(tdi_oe_ext ? din[i] : 1'b1);
            cstp_host_model_inst.step(i == n - 1, din[i], o);
            chk(o, {1'b1, q.pop_front()}, "shifted bit");
        end
    endtask

    task automatic ld_ir(input logic [IR_LEN-1:0] code);
        go(8'h03, 4);
        shift(IR_LEN, 8'(IR_CAPTURE_VAL), 8'(code), IR_LEN);
        go(8'h01, 2);
    endtask

    task automatic dr(input int len, input logic [7:0] cap, input logic [7:0] din, input int n);
        go(8'h01, 3);
        shift(len, cap, din, n);
        go(8'h01, 2);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        $display("CHECK FAILED %0t run limit reached", $time);
        end_sim;
    end

    initial begin
        rst_b = 1'b0;
        {alt_func_sel, alt_func_out, user_io_pin_i, user_out, user_oe} = 5'h00;
        void'($urandom(17));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({config_done_flag_oe, user_mode, tdo_oe}, 8'h04, "reset outputs");
        @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_for(user_mode, 1'b1, CFG_CYC + 200, "user mode after load");
        chk({config_done_flag_o, config_done_flag_oe, config_done_flag_i}, 8'h01, "done released");
        repeat (USER_SETTLE_CYC) @(posedge clk_sys);
        $display("Test reset and configuration finished");

        repeat (8) begin
            @(posedge clk_sys);
            {alt_func_sel, alt_func_out, user_io_pin_i, user_out, user_oe} <= 5'($urandom);
            repeat (3) @(negedge clk_sys);
            if (alt_func_sel)
                chk({user_io_pin_o, user_io_pin_oe, user_in, alt_func_in},
                    {alt_func_out, 1'b1, 1'b0, user_io_pin_i}, "alt path");
            else
                chk({user_io_pin_o, user_io_pin_oe, user_in, alt_func_in},
                    {user_out, user_oe, user_io_pin_i, 1'b0}, "user path");
        end
        $display("Test multi-function pin finished");

        @(posedge clk_sys);
        go(8'h1f, 6);
        ld_ir(INS_USERREG);
        va = 8'($urandom);
        dr(USERREG_LEN, USERREG_RESET, va, USERREG_LEN);
        chk(user_reg, va, "user reg update");
        vb = 8'($urandom);
        dr(USERREG_LEN, va, vb, USERREG_LEN);
        chk(user_reg, vb, "user reg second update");
        foreach (byp_codes[k]) begin
            ld_ir(byp_codes[k]);
            dr(BYPASS_LEN, 8'h00, 8'($urandom), 8);
            chk(user_reg, vb, "user reg kept in bypass");
        end
        $display("Test test port shifting finished");

        @(posedge clk_sys);
        cstp_host_model_inst.done_hold <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(user_mode, 1'b0, "held done blocks user mode");
        repeat (30) @(negedge clk_sys);
        chk(user_mode, 1'b0, "still blocked");
        @(posedge clk_sys);
        cstp_host_model_inst.done_hold <= 1'b0;
        wait_for(user_mode, 1'b1, 10, "user mode after release");
        $display("Test done wire hold finished");

        @(posedge clk_sys);
        cstp_host_model_inst.pulse(RECONF_MIN_CYC - 20);
        repeat (20) @(negedge clk_sys);
        chk({cfg_busy, user_mode}, 8'h01, "short request ignored");
        @(posedge clk_sys);
        cstp_host_model_inst.pulse($urandom_range(RECONF_MIN_CYC + 20, RECONF_MIN_CYC + 4));
        @(negedge clk_sys);
        chk({cfg_busy, user_mode}, 8'h01, "low level alone starts nothing");
        wait_for(cfg_busy, 1'b1, 8, "reload after rising edge");
        chk({user_mode, config_done_flag_o}, 8'h00, "reload leaves user mode");
        wait_for(user_mode, 1'b1, CFG_CYC + 40, "user mode after reload");
        chk(user_reg, vb, "user logic not reset");
        $display("Test reconfiguration request finished");

        @(posedge clk_sys);
        ld_ir(INS_USERREG);
        cstp_host_model_inst.tms_oe_ext <= 1'b0;
        @(posedge clk_sys);
        go(8'h1f, 5);
        cstp_host_model_inst.tms_oe_ext <= 1'b1;
        @(posedge clk_sys);
        go(8'h00, 1);
        cstp_host_model_inst.tdi_oe_ext <= 1'b0;
        @(posedge clk_sys);
        dr(BYPASS_LEN, 8'h00, 8'h00, 4);
        cstp_host_model_inst.tdi_oe_ext <= 1'b1;
        $display("Test released test inputs finished");
        end_sim;
    end
endmodule
